// *** cfc_host_model.sv ***
// host-side model of the two-wire register bus
`timescale 1ns/1ps
module cfc_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_drv_out,
   output logic [7:0] rd_out,
   output logic rd_stb_out
);
   logic r;
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
      rd_out = 8'h00;
      rd_stb_out = 1'b0;
   end
   // half bit: far above the target's sync latency
   task automatic hb;
      repeat (8) @(negedge clk_in);
   endtask
   // data moves only while the clock is low, sampled at end of high
   task automatic bt(input logic b, output logic s);
      repeat (2) @(negedge clk_in);
      sda_drv_out = b;
      hb();
      scl_out = 1'b1;
      hb();
      s = sda_in;
      scl_out = 1'b0;
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic st;
      repeat (2) @(negedge clk_in);
      sda_drv_out = 1'b1;
      hb();
      scl_out = 1'b1;
      hb();
      sda_drv_out = 1'b0;
      hb();
      scl_out = 1'b0;
   endtask
   // stop: data rises while the clock is high, bus left idle
   task automatic sp;
      repeat (2) @(negedge clk_in);
      sda_drv_out = 1'b0;
      hb();
      scl_out = 1'b1;
      hb();
      sda_drv_out = 1'b1;
      hb();
   endtask
   // eight bits msb first, then the ninth; all ones reads a byte
   task automatic by(input logic [7:0] d, input logic a,
      output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
      bt(a, r);
   endtask
   task automatic wr(input logic [6:0] ad, input logic [7:0] c,
      input logic [7:0] d);
      logic [7:0] q;
      st();
      by({ad, 1'b0}, 1'b1, q);
      by(c, 1'b1, q);
      by(d, 1'b1, q);
      sp();
   endtask
   // one byte read, ended by a nack
   task automatic rd(input logic [6:0] ad, input logic [7:0] c);
      logic [7:0] q;
      st();
      by({ad, 1'b0}, 1'b1, q);
      by(c, 1'b1, q);
      st();
      by({ad, 1'b1}, 1'b1, q);
      by(8'hFF, 1'b1, q);
      sp();
      rd_out = q;
      rd_stb_out = 1'b1;
      @(negedge clk_in);
      rd_stb_out = 1'b0;
   endtask
endmodule

// *** cfc_pkg.sv ***
// shared constants and types for the converter fault configuration bank
package cfc_pkg;

   // command codes of the six configuration registers
   localparam logic [7:0] CMD_SW_SETUP = 8'hD2;
   localparam logic [7:0] CMD_ADDR_OVR = 8'hD3;
   localparam logic [7:0] CMD_OV_THR = 8'hD4;
   localparam logic [7:0] CMD_OV_RESP = 8'hD5;
   localparam logic [7:0] CMD_OC_OT = 8'hD6;
   localparam logic [7:0] CMD_PH_LIM = 8'hD7;

   // writable bits of each register; everything else is reserved
   localparam logic [7:0] MASK_SW_SETUP = 8'h07;
   localparam logic [7:0] MASK_ADDR_OVR = 8'hFF;
   localparam logic [7:0] MASK_OV_THR = 8'h0F;
   localparam logic [7:0] MASK_OV_RESP = 8'h0B;
   localparam logic [7:0] MASK_OC_OT = 8'h0F;
   localparam logic [7:0] MASK_PH_LIM = 8'h1F;

   // reset contents
   localparam logic [7:0] RST_SW_SETUP = 8'h00;
   localparam logic [7:0] RST_ADDR_OVR = 8'h00;
   localparam logic [7:0] RST_OV_THR = 8'h00;
   localparam logic [7:0] RST_OV_RESP = 8'h00;
   localparam logic [7:0] RST_OC_OT = 8'h00;
   localparam logic [7:0] RST_PH_LIM = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // bus framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] FIRST_BIT = 4'h1;

   // timing: blanking after a negative current trip, least times
   localparam int CLK_PERIOD_PS = 8000;
   localparam int NEGATIVE_CURRENT_TRIP_SHORT_NS = 100;
   localparam int NEGATIVE_CURRENT_TRIP_LONG_NS = 200;
   localparam int NEGATIVE_CURRENT_TRIP_SHORT_CYC =
      (NEGATIVE_CURRENT_TRIP_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int NEGATIVE_CURRENT_TRIP_LONG_CYC =
      (NEGATIVE_CURRENT_TRIP_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // consecutive valley limit hits before over-current protection
   localparam int OC_CYCLE_LIMIT = 31;

   // over-voltage reaction codes
   localparam logic [1:0] OV_LATCH_DIS = 2'h0;
   localparam logic [1:0] OV_LATCH_NODIS = 2'h1;
   localparam logic [1:0] OV_HICCUP_DIS = 2'h2;
   localparam logic [1:0] OV_HICCUP_NODIS = 2'h3;

   // register layouts, most significant bit first
   typedef struct packed {
      logic [4:0] rsvd;
      logic [1:0] fsw_sel;
      logic light_load_sel;
   } cfc_sw_setup_t;

   typedef struct packed {
      logic ovr_en;
      logic [6:0] addr;
   } cfc_addr_ovr_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic [1:0] release_sel;
      logic [1:0] trip_sel;
   } cfc_ov_thr_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic neg_current_blank_sel;
      logic rsvd2;
      logic [1:0] overvolt_action_sel;
   } cfc_ov_resp_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic overcurrent_action_sel;
      logic [1:0] overtemp_hysteresis;
      logic overtemp_action_sel;
   } cfc_oc_ot_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic [4:0] valley_current_limit;
   } cfc_ph_lim_t;

   typedef struct packed {
      cfc_sw_setup_t sw;
      cfc_addr_ovr_t addr;
      cfc_ov_thr_t ov_thr;
      cfc_ov_resp_t ov_resp;
      cfc_oc_ot_t oc_ot;
      cfc_ph_lim_t ph_lim;
   } cfc_cfg_t;

   // analog comparator and supply sense levels, asynchronous
   typedef struct packed {
      logic fb_above_trip;
      logic fb_below_release;
      logic negative_current_trip;
      logic zero_current;
      logic overtemp;
      logic temp_recovered;
      logic undervolt;
      logic power_cycle;
   } cfc_sense_t;

   // over-voltage flags toward the status registers
   typedef struct packed {
      logic status_byte_ov;
      logic status_word_vout;
      logic status_vout_ov;
   } cfc_status_t;

   typedef enum {
      F_RUN, F_OV_ON, F_OV_OFF, F_OV_HOLD, F_OV_DRAIN, F_HIZ,
      F_LATCHED, F_OT_WAIT
   } cfc_fault_state_t;

   typedef enum {
      B_IDLE, B_ADDR, B_CMD, B_WR, B_ACK, B_RD, B_RACK
   } cfc_bus_state_t;

endpackage

// *** cfc_regs.sv ***
// configuration bank, bus target and fault sequencer of one converter
`timescale 1ns/1ps
module cfc_regs
   import cfc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic phase_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [6:0] addr_pin_in,
   input wire cfc_sense_t sense_in,
   input wire logic valley_exceeded_in,
   output cfc_cfg_t cfg_out,
   output logic [6:0] bus_addr_out,
   output logic low_side_on_out,
   output logic hi_z_out,
   output logic soft_start_out,
   output logic power_good_out,
   output logic alert_n_out,
   output cfc_status_t status_out
);

   ////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic scl_s1, scl_s, scl_q, sda_s1, sda_s, sda_q;
   logic [6:0] pin_s1, pin_s;
   cfc_sense_t sense_s1, s;

   // second stage only feeds logic; the q stage is for edge finding
   always_ff @(posedge clk_in) begin
      scl_s1 <= scl_in;
      scl_s <= scl_s1;
      scl_q <= scl_s;
      sda_s1 <= sda_in;
      sda_s <= sda_s1;
      sda_q <= sda_s;
      pin_s1 <= addr_pin_in;
      pin_s <= pin_s1;
      sense_s1 <= sense_in;
      s <= sense_s1;
   end

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_c = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

   ////////////////////////////////////////////////////////////////////
   // bus target address and register read mux

   cfc_cfg_t cfg;
   logic [6:0] bus_addr;

   // override wins only while its enable bit is set
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bus_addr <= 7'h00;
      end else begin
         bus_addr <= cfg.addr.ovr_en ? cfg.addr.addr : pin_s;
      end
   end

   function automatic logic [7:0] rd_val(input logic [7:0] c,
                                         input cfc_cfg_t g);
      logic [7:0] v;
      v = UNMAPPED_READ;
      case (c)
         CMD_SW_SETUP: v = g.sw & MASK_SW_SETUP;
         CMD_ADDR_OVR: v = g.addr & MASK_ADDR_OVR;
         CMD_OV_THR: v = g.ov_thr & MASK_OV_THR;
         CMD_OV_RESP: v = g.ov_resp & MASK_OV_RESP;
         CMD_OC_OT: v = g.oc_ot & MASK_OC_OT;
         CMD_PH_LIM: v = g.ph_lim & MASK_PH_LIM;
         default: v = UNMAPPED_READ;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // byte engine: address, command, write bytes, read bytes

   cfc_bus_state_t bst, after;
   logic [3:0] bcnt;
   logic [7:0] sh, cmd, wbyte;
   logic wr_stb, sda_oe, sda_drv;
   logic [7:0] rd_byte;

   // a function result cannot be bit-selected, so read data gets a net
   assign rd_byte = rd_val(cmd, cfg);

   // sampling on rise and driving on fall keeps hold time on the line
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bst <= B_IDLE;
         after <= B_IDLE;
         bcnt <= 4'h0;
         sh <= 8'h00;
         cmd <= 8'h00;
         wbyte <= 8'h00;
         wr_stb <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (start_c) begin
            bst <= B_ADDR;
            bcnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            bst <= B_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (bst)
               B_ADDR, B_CMD, B_WR: begin
                  if (scl_rise && bcnt != BYTE_BITS) begin
                     sh <= {sh[6:0], sda_s};
                     bcnt <= bcnt + 4'h1;
                  end else if (scl_fall && bcnt == BYTE_BITS) begin
                     bcnt <= 4'h0;
                     sda_oe <= 1'b1;
                     bst <= B_ACK;
                     if (bst == B_ADDR) begin
                        after <= sh[0] ? B_RD : B_CMD;
                        if (sh[7:1] != bus_addr) begin
                           sda_oe <= 1'b0; // not ours: stay silent
                           bst <= B_IDLE;
                        end
                     end else if (bst == B_CMD) begin
                        cmd <= sh;
                        after <= B_WR;
                     end else begin
                        wbyte <= sh;
                        wr_stb <= 1'b1;
                        after <= B_WR;
                     end
                  end
               end
               B_ACK: begin
                  if (scl_fall) begin
                     bst <= after;
                     sda_oe <= 1'b0;
                     if (after == B_RD) begin
                        sh <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bcnt <= FIRST_BIT;
                     end
                  end
               end
               B_RD: begin
                  if (scl_fall) begin
                     if (bcnt == BYTE_BITS) begin
                        sda_oe <= 1'b0;
                        bst <= B_RACK;
                     end else begin
                        sda_oe <= ~sh[6];
                        sh <= {sh[6:0], 1'b0};
                        bcnt <= bcnt + 4'h1;
                     end
                  end
               end
               B_RACK: begin
                  // master ack asks for the same register again
                  if (scl_rise) begin
                     bst <= sda_s ? B_IDLE : B_ACK;
                     after <= B_RD;
                  end
               end
               default: begin
                  bst <= B_IDLE;
               end
            endcase
         end
      end
   end

   // data line only ever pulls low; the drive level stays zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sda_drv <= 1'b0;
      end else begin
         sda_drv <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register bank; masks keep reserved bits at zero

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg.sw <= cfc_sw_setup_t'(RST_SW_SETUP);
         cfg.addr <= cfc_addr_ovr_t'(RST_ADDR_OVR);
         cfg.ov_thr <= cfc_ov_thr_t'(RST_OV_THR);
         cfg.ov_resp <= cfc_ov_resp_t'(RST_OV_RESP);
         cfg.oc_ot <= cfc_oc_ot_t'(RST_OC_OT);
         cfg.ph_lim <= cfc_ph_lim_t'(RST_PH_LIM);
      end else if (wr_stb) begin
         case (cmd)
            CMD_SW_SETUP: cfg.sw <= wbyte & MASK_SW_SETUP;
            CMD_ADDR_OVR: cfg.addr <= wbyte & MASK_ADDR_OVR;
            CMD_OV_THR: cfg.ov_thr <= wbyte & MASK_OV_THR;
            CMD_OV_RESP: cfg.ov_resp <= wbyte & MASK_OV_RESP;
            CMD_OC_OT: cfg.oc_ot <= wbyte & MASK_OC_OT;
            CMD_PH_LIM: cfg.ph_lim <= wbyte & MASK_PH_LIM;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // switching-cycle domain: consecutive valley limit hits

   logic ph_rst_s1, ph_rst_n, vx_s1, vx, oc_tgl;
   logic [4:0] oc_cnt;

   // reset and comparator are both foreign to this clock
   always_ff @(posedge phase_clk_in) begin
      ph_rst_s1 <= rst_n_in;
      ph_rst_n <= ph_rst_s1;
      vx_s1 <= valley_exceeded_in;
      vx <= vx_s1;
   end

   // each edge is one switching cycle; one clean cycle restarts the run
   always_ff @(posedge phase_clk_in) begin
      if (!ph_rst_n) begin
         oc_cnt <= 5'h00;
         oc_tgl <= 1'b0;
      end else if (!vx) begin
         oc_cnt <= 5'h00;
      end else if (oc_cnt == 5'(OC_CYCLE_LIMIT - 1)) begin
         oc_cnt <= 5'h00;
         oc_tgl <= ~oc_tgl;
      end else begin
         oc_cnt <= oc_cnt + 5'h01;
      end
   end

   a_oc_count: assert property (@(posedge phase_clk_in)
      disable iff (!ph_rst_n)
      (vx && oc_cnt == 5'(OC_CYCLE_LIMIT - 1)) |=> oc_tgl != $past(oc_tgl))
      else $error("over-current not raised on last cycle");
   a_oc_clear: assert property (@(posedge phase_clk_in)
      disable iff (!ph_rst_n)
      !vx |=> oc_cnt == 5'h00 && $stable(oc_tgl))
      else $error("count survived a clean cycle");

   // toggle crossing back to the control clock
   logic oc_t1, oc_t2, oc_t3, oc_evt;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         oc_t1 <= 1'b0;
         oc_t2 <= 1'b0;
         oc_t3 <= 1'b0;
      end else begin
         oc_t1 <= oc_tgl;
         oc_t2 <= oc_t1;
         oc_t3 <= oc_t2;
      end
   end
   assign oc_evt = oc_t2 ^ oc_t3;

   ////////////////////////////////////////////////////////////////////
   // fault sequencer

   cfc_fault_state_t fst;
   logic [4:0] tmr;
   logic ls_on, hiz, ss, ov_set;
   logic [1:0] act;
   assign act = cfg.ov_resp.overvolt_action_sel;

   // blanking is a least time, so its count rounds up
   logic [4:0] blank_len;
   assign blank_len = cfg.ov_resp.neg_current_blank_sel ?
      5'(NEGATIVE_CURRENT_TRIP_LONG_CYC - 1) : 5'(NEGATIVE_CURRENT_TRIP_SHORT_CYC - 1);

   // over-voltage outranks over-current, which outranks temperature
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fst <= F_RUN;
         tmr <= 5'h00;
         ls_on <= 1'b0;
         hiz <= 1'b0;
         ss <= 1'b0;
      end else begin
         ss <= 1'b0;
         if (s.power_cycle) begin
            ls_on <= 1'b0;
            hiz <= 1'b0;
            if (fst != F_RUN) begin
               fst <= F_RUN;
               ss <= 1'b1;
            end
         end else begin
            case (fst)
               F_RUN: begin
                  if (s.fb_above_trip) begin
                     ls_on <= 1'b1;
                     fst <= (act == OV_LATCH_NODIS) ? F_OV_DRAIN : F_OV_ON;
                  end else if (oc_evt || s.undervolt) begin
                     if (cfg.oc_ot.overcurrent_action_sel) begin
                        ss <= 1'b1;
                     end else begin
                        fst <= F_LATCHED;
                     end
                  end else if (s.overtemp) begin
                     fst <= cfg.oc_ot.overtemp_action_sel ?
                        F_OT_WAIT : F_LATCHED;
                  end
               end
               F_OV_ON: begin
                  if (s.negative_current_trip) begin
                     ls_on <= 1'b0;
                     tmr <= blank_len;
                     fst <= F_OV_OFF;
                  end
               end
               F_OV_OFF: begin
                  if (tmr != 5'h00) begin
                     tmr <= tmr - 5'h01;
                  end else if (act == OV_HICCUP_NODIS) begin
                     ss <= 1'b1;
                     fst <= F_RUN;
                  end else if (s.fb_below_release) begin
                     if (act == OV_HICCUP_DIS) begin
                        ss <= 1'b1;
                        fst <= F_RUN;
                     end else begin
                        fst <= F_OV_HOLD;
                     end
                  end else begin
                     ls_on <= 1'b1;
                     fst <= F_OV_ON;
                  end
               end
               F_OV_HOLD: begin
                  if (s.fb_above_trip) begin
                     ls_on <= 1'b1;
                     fst <= F_OV_ON;
                  end
               end
               F_OV_DRAIN: begin
                  if (s.zero_current) begin
                     ls_on <= 1'b0;
                     hiz <= 1'b1;
                     fst <= F_HIZ;
                  end
               end
               F_OT_WAIT: begin
                  if (s.temp_recovered) begin
                     ss <= 1'b1;
                     fst <= F_RUN;
                  end
               end
               F_HIZ, F_LATCHED: begin
                  ls_on <= 1'b0;
               end
               default: begin
                  fst <= F_RUN;
               end
            endcase
         end
      end
   end

   // an over-voltage entry from run or from a latched hold
   assign ov_set = s.fb_above_trip &&
      (fst == F_RUN || fst == F_OV_HOLD);

   cfc_status_t stat;
   logic pg, alert_n;

   // set wins over the power-cycle clear so no trip is lost
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         stat <= '0;
         alert_n <= 1'b1;
      end else if (ov_set) begin
         stat <= '1;
         alert_n <= 1'b0;
      end else if (s.power_cycle) begin
         stat <= '0;
         alert_n <= 1'b1;
      end
   end

   // power good drops a cycle after any fault shows
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pg <= 1'b0;
      end else begin
         pg <= fst == F_RUN && !s.fb_above_trip && !s.overtemp &&
            !s.undervolt && !oc_evt;
      end
   end

   assign cfg_out = cfg;
   assign bus_addr_out = bus_addr;
   assign low_side_on_out = ls_on;
   assign hi_z_out = hiz;
   assign soft_start_out = ss;
   assign power_good_out = pg;
   assign alert_n_out = alert_n;
   assign status_out = stat;
   assign sda_out = sda_drv;
   assign sda_oe_out = sda_oe;

   ////////////////////////////////////////////////////////////////////
   // checks

   a_ov_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ov_set |=> stat == '1 && !alert_n_out)
      else $error("over-voltage flags not raised");
   a_disch_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst == F_OV_ON && s.negative_current_trip && !s.power_cycle)
      |=> !low_side_on_out [*8])
      else $error("low side back on inside blanking");
   a_blank_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst == F_OV_OFF && $past(fst) != F_OV_OFF) |->
      tmr == (cfg.ov_resp.neg_current_blank_sel ?
         5'(NEGATIVE_CURRENT_TRIP_LONG_CYC - 1) : 5'(NEGATIVE_CURRENT_TRIP_SHORT_CYC - 1)))
      else $error("wrong blanking length");
   a_hiz_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (hi_z_out && !s.power_cycle) |=> hi_z_out && !low_side_on_out)
      else $error("left high impedance without power cycle");
   a_hiccup_ss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst == F_OV_OFF && tmr == 5'h00 && s.fb_below_release &&
       act == OV_HICCUP_DIS && !s.power_cycle) |=> soft_start_out)
      else $error("hiccup did not restart");
   a_oc_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst == F_RUN && (oc_evt || s.undervolt) && !s.fb_above_trip &&
       !s.power_cycle && !cfg.oc_ot.overcurrent_action_sel)
      |=> fst == F_LATCHED)
      else $error("over-current or under-voltage not latched");
   a_ot_retry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst == F_OT_WAIT && s.temp_recovered && !s.power_cycle)
      |=> soft_start_out && fst == F_RUN)
      else $error("over-temperature retry missing");
   a_pg_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fst != F_RUN || s.overtemp || s.undervolt || oc_evt)
      |=> !power_good_out)
      else $error("power good high during fault");
   a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cfg_out.sw.rsvd == 5'h00 && cfg_out.ov_resp.rsvd2 == 1'b0 &&
      cfg_out.ov_resp.rsvd == 4'h0 && cfg_out.ph_lim.rsvd == 3'h0)
      else $error("reserved bit reads nonzero");
   a_addr_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in |=> bus_addr_out == ($past(cfg.addr.ovr_en) ?
         $past(cfg.addr.addr) : $past(pin_s)))
      else $error("bus address source wrong");

endmodule

// *** tb_cfc_regs.sv ***
// self-checking bench for the converter fault configuration bank
`timescale 1ns/1ps
module tb_cfc_regs;
   import cfc_pkg::*;
   localparam logic [6:0] PA = 7'h2A;
   logic clk_in = 1'b0;
   logic phase_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic valley = 1'b0;
   logic scl, sda_drv, sda_o, sda_oe, rd_stb, ls_on, hiz, ss, pg, alert_n;
   logic [7:0] rd_val;
   logic [6:0] bus_addr;
   cfc_sense_t sense = '0;
   cfc_cfg_t cfg;
   cfc_status_t status;
   logic [7:0] exp_q[$];
   logic [7:0] masks [6] = '{MASK_SW_SETUP, MASK_ADDR_OVR, MASK_OV_THR,
      MASK_OV_RESP, MASK_OC_OT, MASK_PH_LIM};
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   int seed = 32'h4392;
   // open-drain data line with pull-up
   wire sda = sda_drv & (sda_oe ? sda_o : 1'b1);
   initial forever #4 clk_in = ~clk_in;
   initial begin
      #37;
      forever #80 phase_clk_in = ~phase_clk_in;
   end
   cfc_regs i_cfc_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .phase_clk_in(phase_clk_in), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_pin_in(PA),
      .sense_in(sense), .valley_exceeded_in(valley), .cfg_out(cfg),
      .bus_addr_out(bus_addr), .low_side_on_out(ls_on), .hi_z_out(hiz),
      .soft_start_out(ss), .power_good_out(pg), .alert_n_out(alert_n),
      .status_out(status));
   cfc_host_model i_cfc_host_model (.clk_in(clk_in), .sda_in(sda),
      .scl_out(scl), .sda_drv_out(sda_drv), .rd_out(rd_val),
      .rd_stb_out(rd_stb));
   task automatic chk(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // each read result is matched against the oldest note
   always @(posedge clk_in) begin
      if (rd_stb === 1'b1)
         chk("read byte", rd_val, exp_q.pop_front());
   end
   // hang guard, well above the expected run length
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      logic [7:0] v;
      int n;
      repeat (10) @(negedge phase_clk_in);
      rst_n_in = 1'b1;
      repeat (10) @(negedge clk_in);
      chk("bus address", 8'(bus_addr), 8'(PA));
      chk("power good", 8'(pg), 8'h01);
      // reset contents, then random writes with reserved bits dropped
      for (int i = 0; i < 6; i++) begin
         exp_q.push_back(8'h00);
         i_cfc_host_model.rd(PA, CMD_SW_SETUP + 8'(i));
         if (i != 1) begin
            v = 8'($random(seed));
            i_cfc_host_model.wr(PA, CMD_SW_SETUP + 8'(i), v);
            chk("cfg", cfg[47-8*i -: 8], v & masks[i]);
            exp_q.push_back(v & masks[i]);
            i_cfc_host_model.rd(PA, CMD_SW_SETUP + 8'(i));
         end
      end
      // unmapped command reads as UNMAPPED_READ; a foreign address changes nothing
      exp_q.push_back(UNMAPPED_READ);
      i_cfc_host_model.rd(PA, 8'hD8);
      i_cfc_host_model.wr(~PA, CMD_PH_LIM, ~v);
      exp_q.push_back(v & MASK_PH_LIM);
      i_cfc_host_model.rd(PA, CMD_PH_LIM);
      // address override moves the target, then back to the pin
      i_cfc_host_model.wr(PA, CMD_ADDR_OVR, 8'hC5);
      chk("override", 8'(bus_addr), 8'h45);
      exp_q.push_back(8'hC5);
      i_cfc_host_model.rd(7'h45, CMD_ADDR_OVR);
      i_cfc_host_model.wr(7'h45, CMD_ADDR_OVR, 8'h00);
      i_cfc_host_model.wr(PA, CMD_OV_RESP, 8'h00);
      i_cfc_host_model.wr(PA, CMD_OC_OT, 8'h00);
      // a clean cycle at 30 restarts the count; 31 in a row trips
      valley = 1'b1;
      repeat (30) @(negedge phase_clk_in);
      valley = 1'b0;
      @(negedge phase_clk_in);
      valley = 1'b1;
      repeat (30) @(negedge phase_clk_in);
      valley = 1'b0;
      repeat (3) @(negedge phase_clk_in);
      chk("good at 30", 8'(pg), 8'h01);
      valley = 1'b1;
      repeat (31) @(negedge phase_clk_in);
      valley = 1'b0;
      repeat (4) @(negedge phase_clk_in);
      chk("latched oc", 8'(pg), 8'h00);
      sense.power_cycle = 1'b1;
      repeat (4) @(negedge clk_in);
      sense.power_cycle = 1'b0;
      for (int k = 0; k < 40 && pg !== 1'b1; k++) @(negedge clk_in);
      chk("restart", 8'(pg), 8'h01);
      // over-voltage latch with discharge
      sense.fb_above_trip = 1'b1;
      for (int k = 0; k < 10 && alert_n !== 1'b0; k++) @(negedge clk_in);
      @(negedge clk_in);
      chk("status", 8'(status), 8'h07);
      chk("alert", 8'(alert_n), 8'h00);
      chk("low side", 8'(ls_on), 8'h01);
      chk("good in ov", 8'(pg), 8'h00);
      sense.fb_above_trip = 1'b0;
      sense.negative_current_trip = 1'b1;
      for (int k = 0; k < 10 && ls_on !== 1'b0; k++) @(negedge clk_in);
      sense.negative_current_trip = 1'b0;
      n = 0;
      while (ls_on === 1'b0 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      chk("blank", 8'(n inside {[12:16]}), 8'h01);
      chk("pulse again", 8'(ls_on), 8'h01);
      sense.fb_below_release = 1'b1;
      sense.negative_current_trip = 1'b1;
      repeat (60) @(negedge clk_in);
      chk("held off", 8'(ls_on), 8'h00);
      chk("still set", 8'(status), 8'h07);
      sense = '0;
      sense.power_cycle = 1'b1;
      repeat (4) @(negedge clk_in);
      sense.power_cycle = 1'b0;
      repeat (10) @(negedge clk_in);
      chk("cleared", 8'({status, alert_n}), 8'h01);
      // hiccup with discharge ends in a soft start pulse
      i_cfc_host_model.wr(PA, CMD_OV_RESP, 8'h02);
      sense.fb_above_trip = 1'b1;
      for (int k = 0; k < 10 && ls_on !== 1'b1; k++) @(negedge clk_in);
      sense = '0;
      sense.fb_below_release = 1'b1;
      sense.negative_current_trip = 1'b1;
      for (int k = 0; k < 40 && ss !== 1'b1; k++) @(negedge clk_in);
      chk("hiccup", 8'({ss, ls_on}), 8'h02);
      // latch without discharge goes high impedance at zero current
      i_cfc_host_model.wr(PA, CMD_OV_RESP, 8'h01);
      sense = '0;
      sense.fb_above_trip = 1'b1;
      repeat (6) @(negedge clk_in);
      sense.zero_current = 1'b1;
      for (int k = 0; k < 10 && hiz !== 1'b1; k++) @(negedge clk_in);
      chk("hi-z", 8'({hiz, ls_on, pg}), 8'h04);
      stop_test();
   end
endmodule
